/* tws_pkg.sv */
// package: register map, status codes and timing of the two-wire master
package tws_pkg;
  // ----------------------------------------
  // register map (index, byte address is 4x)
  // ----------------------------------------
  localparam int         ADDR_W   = 10;
  localparam logic [7:0] IDX_CTRL = 8'hAA;
  localparam logic [7:0] IDX_CODE = 8'hAB;
  localparam logic [7:0] IDX_BYTE = 8'hAD;
  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int CB_RATE_HI  = 7;
  localparam int CB_ON       = 6;
  localparam int CB_STA      = 5;
  localparam int CB_STO      = 4;
  localparam int CB_SI       = 3;
  localparam int CB_AA       = 2;
  localparam int CB_RATE_MID = 1;
  localparam int CB_RATE_LO  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'hF8;
  localparam logic [7:0] BYTE_RST = 8'hFF;
  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam logic [7:0] SC_START    = 8'h08;
  localparam logic [7:0] SC_RSTART   = 8'h10;
  localparam logic [7:0] SC_AW_ACK   = 8'h18;
  localparam logic [7:0] SC_AW_NACK  = 8'h20;
  localparam logic [7:0] SC_DT_ACK   = 8'h28;
  localparam logic [7:0] SC_DT_NACK  = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_AR_ACK   = 8'h40;
  localparam logic [7:0] SC_AR_NACK  = 8'h48;
  localparam logic [7:0] SC_DR_ACK   = 8'h50;
  localparam logic [7:0] SC_DR_NACK  = 8'h58;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int BASE_RATE_HZ = 100_000;
  localparam int QDIV_BASE    = CLK_HZ / (4 * BASE_RATE_HZ);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_START, ST_BYTE, ST_HOLD, ST_STOP
  } tws_state_t;
endpackage : tws_pkg

/* tws_master.sv */
// module: two-wire bus master engine with AXI4-Lite registers
`timescale 1ns/1ps
// Overview of operation
// - START only once bus seen free
// - after START: flag set, code 08h
// - after repeated START: flag, code 10h
// - address direction bit picks transmit/receive
// - write address: 18h, 20h or 38h
// - data sent: 28h ack, 30h nack
// - byte writes ignored while flag low
// - no bus activity while flag set
// - halt alone: STOP, then halt cleared
// - halt with begin: STOP then START
// - begin alone after result: repeated START
// - arbitration lost: release or START later
// - in 10h, loaded address picks mode
// - read address: 40h, 48h or 38h
// - receive byte, answer per ack_grant
// - received: 50h/58h, byte readable
// - read high, ack low, eight bits
// - SCL held low while flag set, except after arbitration loss
// - no flag after STOP
// - code low bits zero
// - three rate bits pick bit rate
module tws_master import tws_pkg::*; #(
  parameter int QDIV = QDIV_BASE
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);
  if (QDIV < 1 || QDIV > 65535) begin : g_bad_qdiv
    $error("QDIV out of range");
  end
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tws_state_t  st_r;
  logic [1:0]  q_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r, byte_r, ctrl_r, ctrl_nxt, wdat_r;
  logic [4:0]  code_r;
  logic        rx_r, addr_r, lost_r, rep_r, ack_r, busy_r, tick_r;
  logic        aw_hold_r, w_hold_r, wstb_r;
  logic [7:0]  widx_r;
  logic [15:0] div_r;
  logic [1:0]  scl_s_r, sda_s_r;
  logic        sda_d_r;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire       on     = ctrl_r[CB_ON];
  wire       begin_cond_req    = ctrl_r[CB_STA];
  wire       halt_cond_req    = ctrl_r[CB_STO];
  wire       si     = ctrl_r[CB_SI];
  wire       aa     = ctrl_r[CB_AA];
  wire [2:0] rate   = {ctrl_r[CB_RATE_HI], ctrl_r[CB_RATE_MID],
                       ctrl_r[CB_RATE_LO]};
  wire       scl_s  = scl_s_r[1];
  wire       sda_s  = sda_s_r[1];
  wire       aw_tk  = awvalid & awready;
  wire       w_tk   = wvalid & wready;
  wire       ar_tk  = arvalid & arready;
  wire       wr_go  = aw_hold_r & w_hold_r & ~bvalid;
  wire       w_hit  = widx_r == IDX_CTRL || widx_r == IDX_CODE ||
                      widx_r == IDX_BYTE;
  wire       ctl_wr = wr_go & wstb_r & widx_r == IDX_CTRL;
  wire       byt_wr = wr_go & wstb_r & widx_r == IDX_BYTE;
  wire [7:0] ridx   = araddr[9:2];
  wire       r_hit  = ridx == IDX_CTRL || ridx == IDX_CODE ||
                      ridx == IDX_BYTE;
  wire [7:0] rd_val = ridx == IDX_CTRL ? ctrl_r :
                      ridx == IDX_CODE ? {code_r, 3'h0} :
                      ridx == IDX_BYTE ? byte_r : 8'h00;
  wire [15:0] qsh   = 16'(QDIV) >> rate;
  wire [15:0] qdiv  = qsh == 16'h0000 ? 16'h0001 : qsh;
  wire       rxd    = rx_r & ~addr_r;
  wire       step   = tick_r & (q_r != 2'd2 | scl_s);
  wire       start_end = st_r == ST_START & q_r == 2'd3 & tick_r;
  wire       byte_end  = st_r == ST_BYTE & q_r == 2'd3 & tick_r &
                         bit_r == 4'd8;
  wire       stop_end  = st_r == ST_STOP & q_r == 2'd2 & step;
  wire       arb_loss  = st_r == ST_BYTE & q_r == 2'd2 & step & ~rxd &
                         bit_r < 4'd8 & sh_r[7] & ~sda_s;
  wire       si_set    = start_end | byte_end | arb_loss;
  wire       release_go = st_r == ST_HOLD & ~si;
  wire [7:0] end_code =
    addr_r ? (sh_r[0] ? (ack_r ? SC_AR_NACK : SC_AR_ACK)
                      : (ack_r ? SC_AW_NACK : SC_AW_ACK)) :
    rxd    ? (aa ? SC_DR_ACK : SC_DR_NACK) :
             (ack_r ? SC_DT_NACK : SC_DT_ACK);
  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      widx_r    <= 8'h00;
      wdat_r    <= 8'h00;
      wstb_r    <= 1'b0;
    end else begin
      if (aw_tk) widx_r <= awaddr[9:2];
      if (w_tk) begin
        wdat_r <= wdata[7:0];
        wstb_r <= wstrb[0];
      end
      aw_hold_r <= aw_tk | (aw_hold_r & ~wr_go);
      w_hold_r  <= w_tk | (w_hold_r & ~wr_go);
      awready   <= ~(aw_tk | (aw_hold_r & ~wr_go));
      wready    <= ~(w_tk | (w_hold_r & ~wr_go));
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~(ar_tk | (rvalid & ~rready));
      if (ar_tk) begin
        rvalid <= 1'b1;
        rdata  <= {24'h00_0000, rd_val};
        rresp  <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // control, code and byte registers
  // ----------------------------------------
  always_comb begin
    ctrl_nxt = ctl_wr ? wdat_r : ctrl_r;
    ctrl_nxt[CB_SI] = si_set | (si & ~(ctl_wr & ~wdat_r[CB_SI]));
    ctrl_nxt[CB_STO] = ctl_wr ? wdat_r[CB_STO] : halt_cond_req & ~stop_end;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_r <= CTRL_RST;
    else ctrl_r <= ctrl_nxt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) code_r <= CODE_RST[7:3];
    else if (start_end) code_r <= rep_r ? SC_RSTART[7:3] : SC_START[7:3];
    else if (arb_loss) code_r <= SC_ARB_LOST[7:3];
    else if (byte_end) code_r <= end_code[7:3];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) byte_r <= BYTE_RST;
    else if (byte_end) byte_r <= sh_r;
    else if (byt_wr && si) byte_r <= wdat_r;
  end
  // ----------------------------------------
  // pin sync, bus monitor, rate divider
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      sda_d_r <= 1'b1;
      busy_r  <= 1'b0;
      div_r   <= 16'h0000;
      tick_r  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      sda_d_r <= sda_s;
      if (scl_s & sda_d_r & ~sda_s) busy_r <= 1'b1;
      else if (scl_s & ~sda_d_r & sda_s) busy_r <= 1'b0;
      tick_r <= div_r == 16'h0000;
      div_r  <= div_r == 16'h0000 ? qdiv - 16'h0001 : div_r - 16'h0001;
    end
  end
  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !on) begin
      st_r <= ST_IDLE;
      q_r <= 2'd0;
      bit_r <= 4'd0;
      sh_r <= 8'h00;
      rx_r <= 1'b0;
      addr_r <= 1'b0;
      lost_r <= 1'b0;
      rep_r <= 1'b0;
      ack_r <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: if (begin_cond_req && !si) st_r <= ST_WAIT;
        ST_WAIT: if (!busy_r && tick_r) begin
          st_r <= ST_START;
          q_r <= 2'd0;
          rep_r <= 1'b0;
          lost_r <= 1'b0;
        end
        ST_START: if (step) begin
          q_r <= q_r + 2'd1;
          if (q_r == 2'd0) sda_oe <= 1'b0;
          if (q_r == 2'd1) scl_oe <= 1'b0;
          if (q_r == 2'd2) sda_oe <= 1'b1;
          if (q_r == 2'd3) begin
            scl_oe <= 1'b1;
            addr_r <= 1'b1;
            st_r <= ST_HOLD;
          end
        end
        ST_BYTE: if (step) begin
          q_r <= q_r + 2'd1;
          if (q_r == 2'd0)
            sda_oe <= bit_r == 4'd8 ? rxd & aa : ~rxd & ~sh_r[7];
          if (q_r == 2'd1) scl_oe <= 1'b0;
          if (q_r == 2'd2) begin
            if (bit_r == 4'd8) ack_r <= sda_s;
            else sh_r <= {sh_r[6:0], sda_s};
          end
          if (arb_loss) begin
            lost_r <= 1'b1;
            sda_oe <= 1'b0;
            st_r <= ST_HOLD;
          end
          if (q_r == 2'd3) begin
            scl_oe <= 1'b1;
            bit_r <= bit_r + 4'd1;
            if (bit_r == 4'd8) begin
              st_r <= ST_HOLD;
              if (addr_r) rx_r <= sh_r[0];
              addr_r <= 1'b0;
            end
          end
        end
        ST_HOLD: if (release_go) begin
          q_r <= 2'd0;
          bit_r <= 4'd0;
          if (halt_cond_req) st_r <= ST_STOP;
          else if (begin_cond_req && lost_r) st_r <= ST_WAIT;
          else if (begin_cond_req) begin
            st_r <= ST_START;
            rep_r <= 1'b1;
          end else if (lost_r) begin
            st_r <= ST_IDLE;
            lost_r <= 1'b0;
          end else begin
            st_r <= ST_BYTE;
            sh_r <= byte_r;
          end
        end
        ST_STOP: if (step) begin
          q_r <= q_r + 2'd1;
          if (q_r == 2'd0) sda_oe <= 1'b1;
          if (q_r == 2'd1) scl_oe <= 1'b0;
          if (q_r == 2'd2) begin
            sda_oe <= 1'b0;
            lost_r <= 1'b0;
            st_r <= begin_cond_req ? ST_WAIT : ST_IDLE;
          end
        end
      endcase
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hold_scl;
    st_r == ST_HOLD && si && !lost_r |-> scl_oe;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("scl not held");
  property p_start_code;
    start_end |=> si && (code_r == SC_START[7:3] ||
                         code_r == SC_RSTART[7:3]);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code");
  property p_rstart_code;
    start_end && rep_r |=> code_r == SC_RSTART[7:3];
  endproperty
  a_rstart_code: assert property (p_rstart_code) else $error("rs code");
  property p_no_si_stop;
    stop_end && !si |=> !si;
  endproperty
  a_no_si_stop: assert property (p_no_si_stop) else $error("flag at stop");
  property p_byte_keep;
    byt_wr && !si && !byte_end |=> $stable(byte_r);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte changed");
  property p_suspend;
    st_r == ST_HOLD && si && on |=> st_r == ST_HOLD && $stable(sda_oe);
  endproperty
  a_suspend: assert property (p_suspend) else $error("moved while held");
  property p_sto_clear;
    stop_end && !ctl_wr |=> !halt_cond_req;
  endproperty
  a_sto_clear: assert property (p_sto_clear) else $error("halt kept");
  property p_wait_busy;
    st_r == ST_WAIT && busy_r && on |=> st_r == ST_WAIT;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("start on busy");
  property p_loss_code;
    arb_loss |=> si && code_r == SC_ARB_LOST[7:3] && !sda_oe;
  endproperty
  a_loss_code: assert property (p_loss_code) else $error("loss code");
endmodule : tws_master

/* tws_slave_model.sv */
// file: behavioural two-wire slave partner for the master engine bench
`timescale 1ns/1ps
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic       nak,
  output logic            sda_oe
);
  logic [7:0] sh;
  int         n;
  logic       act;
  logic       rd;
  logic       ad;
  // ----------------------------------------
  // framing and bit handling
  // ----------------------------------------
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    ad = 1'b0;
    n = 0;
  end
  always @(negedge sda) if (scl) begin
    n = 0;
    act = 1'b1;
    ad = 1'b1;
    rd = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && rd && sda) act = 1'b0;
    n = n + 1;
  end
  // next byte loaded while clock held low
  always @(tx_byte) if (act && rd && !ad && n < 8 && !scl)
    sda_oe = !tx_byte[7-n];
  always @(negedge scl) if (act) begin
    sda_oe = 1'b0;
    if (n == 9) n = 0;
    if (n == 8 && ad) begin
      act = (sh[7:1] == ADDR);
      rd = sh[0];
      sda_oe = act;
      ad = 1'b0;
    end else if (n == 8) begin
      sda_oe = !rd && !nak;
    end else if (rd && !ad) begin
      sda_oe = !tx_byte[7-n];
    end
  end
endmodule : tws_slave_model

/* two_wire_master_status_engine_test.sv */
// file: self-checking bench of the two-wire master engine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module two_wire_master_status_engine_test import tws_pkg::*; ;
  logic              aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, r, wresp;
  logic              scl_oe, sda_oe, slv_oe, tb_oe, nak;
  logic              scl_o, sda_o;
  logic [7:0]        tx_byte, d, b;
  int                err_total, cmp_count, cyc, seed;
  wire               scl = ~scl_oe;
  wire               sda = ~(sda_oe | slv_oe | tb_oe);
  // ----------------------------------------
  // design, partner, clock
  // ----------------------------------------
  tws_master #(.QDIV(4)) tws_master_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(sda_oe));
  tws_slave_model tws_slave_model_inst (
    .scl(scl), .sda(sda), .tx_byte(tx_byte), .nak(nak), .sda_oe(slv_oe));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      give_verdict;
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wresp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [7:0] v,
                    output logic [1:0] e);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata[7:0];
    e = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic step(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] v;
    logic [1:0] s;
    wr(IDX_CTRL, c);
    v = 8'h0;
    while (v[CB_SI] !== 1'b1) rd(IDX_CTRL, v, s);
    rd(IDX_CODE, v, s);
    `CHK("code", e, v)
  endtask : step
  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h316cc26f;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {tb_oe, nak, tx_byte} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CTRL, b, r); `CHK("ctrl_rst", CTRL_RST, b)
    rd(IDX_CODE, b, r); `CHK("code_rst", CODE_RST, b)
    rd(IDX_BYTE, b, r); `CHK("byte_rst", BYTE_RST, b)
    rd(8'h00, b, r); `CHK("unmapped", RESP_SLVERR, r)
    wr(8'h00, 8'h11);
    `CHK("wr_unmap", RESP_SLVERR, wresp)
    wr(IDX_BYTE, 8'h5A);
    `CHK("wr_resp", RESP_OKAY, wresp)
    rd(IDX_BYTE, b, r); `CHK("byte_ign", BYTE_RST, b)
    tb_oe <= 1'b1;
    wr(IDX_CTRL, 8'h60);
    repeat (100) @(posedge aclk);
    `CHK("busy_wait", 1'b0, sda_oe)
    tb_oe <= 1'b0;
    step(8'h60, SC_START);
    repeat (20) @(posedge aclk);
    `CHK("scl_hold", 1'b1, scl_oe)
    wr(IDX_BYTE, {7'h2A, 1'b0});
    step(8'h40, SC_AW_ACK);
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      wr(IDX_BYTE, d);
      nak <= (i == 1);
      step(8'h40, (i == 1) ? SC_DT_NACK : SC_DT_ACK);
      rd(IDX_BYTE, b, r); `CHK("sent", d, b)
    end
    nak <= 1'b0;
    step(8'h60, SC_RSTART);
    wr(IDX_BYTE, {7'h2A, 1'b1});
    step(8'h40, SC_AR_ACK);
    for (int i = 0; i < 2; i++) begin
      tx_byte <= 8'($random(seed));
      step((i == 1) ? 8'h40 : 8'h44, (i == 1) ? SC_DR_NACK : SC_DR_ACK);
      rd(IDX_BYTE, b, r); `CHK("rcvd", tx_byte, b)
    end
    wr(IDX_CTRL, 8'h50);
    repeat (200) @(posedge aclk);
    rd(IDX_CTRL, b, r); `CHK("stop_ctrl", 8'h40, b)
    step(8'h61, SC_START);
    wr(IDX_BYTE, {7'h55, 1'b0});
    step(8'h40, SC_AW_NACK);
    step(8'h70, SC_START);
    wr(IDX_BYTE, {7'h55, 1'b1});
    step(8'h40, SC_AR_NACK);
    step(8'h70, SC_START);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_BYTE, 8'hFF);
      tb_oe <= 1'b1;
      step(8'h40, SC_ARB_LOST);
      tb_oe <= 1'b0;
      if (k == 0) step(8'h60, SC_START);
    end
    wr(IDX_CTRL, 8'h40);
    repeat (200) @(posedge aclk);
    `CHK("idle_scl", 1'b0, scl_oe)
    rd(IDX_CTRL, b, r); `CHK("idle_ctrl", 8'h40, b)
    `CHK("drv_lo", 2'b00, {scl_o, sda_o})
    give_verdict;
  end
endmodule : two_wire_master_status_engine_test
